/* File: design/cdw_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cdw_consts.svh"
module cdw_core (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core memory
  output cdw_pkg::cdw_mem_req_t mem_o,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  // peripheral buses
  input wire logic [15:0] input_data_lines,
  output logic [15:0] output_data_lines,
  output logic [9:0] device_select_lines,
  output logic io_strobe
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [16:0] add_ovf(input logic [15:0] a, input logic [15:0] b,
                                          input logic cin);
    logic [15:0] s;
    s = a + b + {15'h0000, cin};
    add_ovf = {(a[15] == b[15]) && (s[15] != a[15]), s};
  endfunction : add_ovf

  function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] nw,
                                            input logic en);
    lane_merge = en ? nw : old;
  endfunction : lane_merge

  function automatic cdw_pkg::cdw_class_t word_class(input logic [15:0] w);
    cdw_pkg::cdw_word_t f;
    f = cdw_pkg::cdw_word_t'(w);
    if (f.op == `CDW_OP_IOT)
      word_class = cdw_pkg::CLS_IOT;
    else if (f.op != `CDW_OP_GROUP0)
      word_class = cdw_pkg::CLS_MEMREF;
    else if (!f.ind && f.idx)
      word_class = cdw_pkg::CLS_SHIFT;
    else
      word_class = cdw_pkg::CLS_GENERIC;
  endfunction : word_class

  // ----------------------------------------
  // state
  // ----------------------------------------
  cdw_pkg::cdw_state_t state_q;
  logic [15:0] acc_q;
  logic [15:0] ext_q;
  logic [13:0] pc_q;
  logic [15:0] mdr_q;
  logic [15:0] mar_q;
  logic [15:0] ea_q;
  logic [5:0] opreg_q;
  logic carry_q;
  logic run_q;
  logic step_q;
  logic [15:0] in_s1_q, in_s2_q, in_s3_q, in_q;
  logic [15:0] bus_a, bus_b;
  logic [16:0] sum;
  logic wb_req, wb_wr, idle;
  logic [31:0] wr_word;
  cdw_pkg::cdw_word_t ir;
  cdw_pkg::cdw_class_t ir_class;
  logic [5:0] shift_cnt;
  logic [30:0] long_val;

  assign ir = cdw_pkg::cdw_word_t'(mdr_q);
  assign ir_class = word_class({opreg_q, 10'h000});
  assign idle = (state_q == cdw_pkg::ST_IDLE);
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign wr_word = {lane_merge(8'h00, wb_dat_i[31:24], wb_sel_i[3]),
                    lane_merge(8'h00, wb_dat_i[23:16], wb_sel_i[2]),
                    lane_merge(8'h00, wb_dat_i[15:8], wb_sel_i[1]),
                    lane_merge(8'h00, wb_dat_i[7:0], wb_sel_i[0])};
  assign shift_cnt = mdr_q[5:0];
  assign long_val = {acc_q, ext_q[14:0]};

  // ----------------------------------------
  // internal buses and adder
  // ----------------------------------------
  always_comb
  begin
    bus_a = acc_q;
    bus_b = mdr_q;
    unique case (state_q)
      cdw_pkg::ST_IDX_ADD:
      begin
        bus_a = ea_q;
        bus_b = mdr_q;
      end
      cdw_pkg::ST_EXEC:
      begin
        if (ir_class == cdw_pkg::CLS_IOT && {opreg_q[5:4], ir.op} == `CDW_OP6_INPUT)
          bus_b = in_q;
        else if (ir_class == cdw_pkg::CLS_IOT)
          bus_b = acc_q;
        else
          bus_b = (opreg_q[3:0] == `CDW_OP_ADD) ? mdr_q : ~mdr_q;
      end
      default:
      begin
        bus_a = acc_q;
        bus_b = mdr_q;
      end
    endcase
  end

  assign sum = add_ovf(bus_a, bus_b, (state_q == cdw_pkg::ST_EXEC) &&
                       (opreg_q[3:0] != `CDW_OP_ADD));

  // ----------------------------------------
  // input line synchroniser
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    in_s1_q <= input_data_lines;
    in_s2_q <= in_s1_q;
    in_s3_q <= in_s2_q;
    if (srst)
      in_q <= `CDW_RST_WORD;
    else if (in_s2_q == in_s3_q)
      in_q <= in_s3_q;
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i)
        unique case (wb_adr_i)
          `CDW_OFF_CTRL: wb_dat_o <= {31'h0000_0000, run_q};
          `CDW_OFF_PC: wb_dat_o <= {18'h00000, pc_q};
          `CDW_OFF_ACC: wb_dat_o <= {16'h0000, acc_q};
          `CDW_OFF_EXT: wb_dat_o <= {16'h0000, ext_q};
          `CDW_OFF_STATUS: wb_dat_o <= {18'h00000, opreg_q, 6'h00, !idle, carry_q};
          `CDW_OFF_MDR: wb_dat_o <= {16'h0000, mdr_q};
          `CDW_OFF_MAR: wb_dat_o <= {16'h0000, mar_q};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      run_q <= 1'b0;
      step_q <= 1'b0;
    end
    else
    begin
      step_q <= 1'b0;
      if (wb_wr && wb_adr_i == `CDW_OFF_CTRL && wb_sel_i[0])
      begin
        run_q <= wr_word[`CDW_CTRL_RUN_BIT];
        step_q <= wr_word[`CDW_CTRL_STEP_BIT];
      end
    end
  end

  // ----------------------------------------
  // carry flag, set wins over clear
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      carry_q <= 1'b0;
    else if (state_q == cdw_pkg::ST_EXEC && ir_class == cdw_pkg::CLS_MEMREF &&
             (opreg_q[3:0] == `CDW_OP_ADD || opreg_q[3:0] == `CDW_OP_SUB) && sum[16])
      carry_q <= 1'b1;
    else if (state_q == cdw_pkg::ST_EXEC && ir_class == cdw_pkg::CLS_SHIFT &&
             mdr_q[15:6] == `CDW_OP10_ALS &&
             ($signed(acc_q << shift_cnt) >>> shift_cnt) != $signed(acc_q))
      carry_q <= 1'b1;
    else if (wb_wr && wb_adr_i == `CDW_OFF_STATUS && wb_sel_i[0] &&
             wr_word[`CDW_STAT_CARRY_BIT])
      carry_q <= 1'b0;
  end

  // ----------------------------------------
  // sequencer and register transfers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= cdw_pkg::ST_IDLE;
      acc_q <= `CDW_RST_WORD;
      ext_q <= `CDW_RST_WORD;
      pc_q <= `CDW_RST_PC;
      mdr_q <= `CDW_RST_WORD;
      mar_q <= `CDW_RST_WORD;
      ea_q <= `CDW_RST_WORD;
      opreg_q <= `CDW_RST_OPREG;
      mem_o <= '0;
      output_data_lines <= `CDW_RST_WORD;
      device_select_lines <= 10'h000;
      io_strobe <= 1'b0;
    end
    else
    begin
      io_strobe <= 1'b0;
      unique case (state_q)
        cdw_pkg::ST_IDLE:
        begin
          if (wb_wr && wb_adr_i == `CDW_OFF_PC)
            pc_q <= wr_word[13:0];
          if (wb_wr && wb_adr_i == `CDW_OFF_ACC)
            acc_q <= wr_word[15:0];
          if (wb_wr && wb_adr_i == `CDW_OFF_EXT)
            ext_q <= wr_word[15:0];
          if (run_q || step_q)
          begin
            mar_q <= {2'b00, pc_q};
            mem_o <= '{req: 1'b1, we: 1'b0, addr: {2'b00, pc_q}, wdata: mdr_q};
            state_q <= cdw_pkg::ST_FETCH;
          end
        end
        cdw_pkg::ST_FETCH:
          if (mem_ack)
          begin
            mem_o.req <= 1'b0;
            mdr_q <= mem_rdata;
            opreg_q <= mem_rdata[15:10];
            state_q <= cdw_pkg::ST_DECODE;
          end
        cdw_pkg::ST_DECODE:
          if (ir_class == cdw_pkg::CLS_MEMREF)
          begin
            ea_q <= {2'b00, ir.sec ? pc_q[13:9] : 5'h00, ir.addr};
            mar_q <= {2'b00, ir.sec ? pc_q[13:9] : 5'h00, ir.addr};
            if (ir.idx)
            begin
              mar_q <= `CDW_INDEX_LOC;
              mem_o <= '{req: 1'b1, we: 1'b0, addr: `CDW_INDEX_LOC, wdata: mdr_q};
              state_q <= cdw_pkg::ST_IDX_RD;
            end
            else if (ir.ind)
            begin
              mem_o <= '{req: 1'b1, we: 1'b0, addr: {2'b00, ir.sec ? pc_q[13:9] : 5'h00,
                                                      ir.addr}, wdata: mdr_q};
              state_q <= cdw_pkg::ST_INDIR;
            end
            else if (ir.op == `CDW_OP_JUMP)
              state_q <= cdw_pkg::ST_OPND;
            else
            begin
              mem_o <= '{req: 1'b1, we: 1'b0, addr: {2'b00, ir.sec ? pc_q[13:9] : 5'h00,
                                                      ir.addr}, wdata: mdr_q};
              state_q <= cdw_pkg::ST_OPND;
            end
          end
          else
            state_q <= cdw_pkg::ST_EXEC;
        cdw_pkg::ST_IDX_RD:
          if (mem_ack)
          begin
            mem_o.req <= 1'b0;
            mdr_q <= mem_rdata;
            state_q <= cdw_pkg::ST_IDX_ADD;
          end
        cdw_pkg::ST_IDX_ADD:
        begin
          mar_q <= {2'b00, sum[13:0]};
          if (opreg_q[5])
          begin
            mem_o <= '{req: 1'b1, we: 1'b0, addr: {2'b00, sum[13:0]}, wdata: mdr_q};
            state_q <= cdw_pkg::ST_INDIR;
          end
          else if (opreg_q[3:0] == `CDW_OP_JUMP)
            state_q <= cdw_pkg::ST_OPND;
          else
          begin
            mem_o <= '{req: 1'b1, we: 1'b0, addr: {2'b00, sum[13:0]}, wdata: mdr_q};
            state_q <= cdw_pkg::ST_OPND;
          end
        end
        cdw_pkg::ST_INDIR:
          if (mem_ack)
          begin
            mdr_q <= mem_rdata;
            mar_q <= {2'b00, mem_rdata[13:0]};
            ea_q <= {2'b00, mem_rdata[13:0]};
            opreg_q[5:4] <= mem_rdata[15:14];
            if (mem_rdata[14])
            begin
              mar_q <= `CDW_INDEX_LOC;
              mem_o.addr <= `CDW_INDEX_LOC;
              state_q <= cdw_pkg::ST_IDX_RD;
            end
            else if (mem_rdata[15])
              mem_o.addr <= {2'b00, mem_rdata[13:0]};
            else if (opreg_q[3:0] == `CDW_OP_JUMP)
            begin
              mem_o.req <= 1'b0;
              state_q <= cdw_pkg::ST_OPND;
            end
            else
            begin
              mem_o.addr <= {2'b00, mem_rdata[13:0]};
              state_q <= cdw_pkg::ST_OPND;
            end
          end
        cdw_pkg::ST_OPND:
          if (opreg_q[3:0] == `CDW_OP_JUMP)
          begin
            pc_q <= mar_q[13:0];
            state_q <= cdw_pkg::ST_NEXT;
          end
          else if (mem_ack)
          begin
            mem_o.req <= 1'b0;
            mdr_q <= mem_rdata;
            state_q <= cdw_pkg::ST_EXEC;
          end
        cdw_pkg::ST_EXEC:
        begin
          pc_q <= pc_q + 14'h0001;
          state_q <= cdw_pkg::ST_NEXT;
          unique case (ir_class)
            cdw_pkg::CLS_MEMREF:
              unique case (opreg_q[3:0])
                `CDW_OP_ADD, `CDW_OP_SUB: acc_q <= sum[15:0];
                `CDW_OP_CMP:
                  if (acc_q == mdr_q)
                    pc_q <= pc_q + 14'h0002;
                default: acc_q <= acc_q;
              endcase
            cdw_pkg::CLS_IOT:
            begin
              device_select_lines <= mdr_q[9:0];
              io_strobe <= 1'b1;
              if (mdr_q[15:10] == `CDW_OP6_INPUT)
                acc_q <= bus_b;
              else if (mdr_q[15:10] == `CDW_OP6_OUTPUT)
                output_data_lines <= bus_b;
            end
            cdw_pkg::CLS_SHIFT:
              if (mdr_q[15:6] == `CDW_OP10_ALS)
                acc_q <= acc_q << shift_cnt;
              else if (mdr_q[15:6] == `CDW_OP10_LLS)
              begin
                acc_q <= 16'((long_val << shift_cnt) >> 15);
                ext_q <= {1'b0, 15'(long_val << shift_cnt)};
              end
            cdw_pkg::CLS_GENERIC:
              if (mdr_q == `CDW_WORD_CLEAR_ACC)
                acc_q <= `CDW_RST_WORD;
          endcase
        end
        cdw_pkg::ST_NEXT:
        begin
          mar_q <= {2'b00, pc_q};
          if (run_q)
          begin
            mem_o <= '{req: 1'b1, we: 1'b0, addr: {2'b00, pc_q}, wdata: mdr_q};
            state_q <= cdw_pkg::ST_FETCH;
          end
          else
            state_q <= cdw_pkg::ST_IDLE;
        end
        default: state_q <= cdw_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : cdw_core
`default_nettype wire

/* File: dv/cdw_core_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module cdw_core_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // core memory
  input wire cdw_pkg::cdw_mem_req_t mem_o,
  input wire logic mem_ack,
  // peripheral buses
  input wire logic [15:0] output_data_lines,
  input wire logic [9:0] device_select_lines,
  input wire logic io_strobe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ----------------------------------------
  // register bus handshake
  // ----------------------------------------
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> (wb_dat_o == 32'h0))
    else $error("read data not zero outside ack");
  // ----------------------------------------
  // core memory and peripherals
  // ----------------------------------------
  a_mem_hold: assert property ((mem_o.req && !mem_ack) |=> (mem_o.req && $stable(mem_o.addr)))
    else $error("memory request changed before answer");
  a_mem_read: assert property (mem_o.req |-> (!mem_o.we && (mem_o.addr[15:14] == 2'h0)))
    else $error("memory request not a 14-bit read");
  a_io_pulse: assert property (io_strobe |=> !io_strobe)
    else $error("io strobe longer than one cycle");
  a_out_cause: assert property ($changed(output_data_lines) |-> io_strobe)
    else $error("output lines changed without io strobe");
  a_sel_cause: assert property ($changed(device_select_lines) |-> io_strobe)
    else $error("select lines changed without io strobe");
endmodule : cdw_core_assertions
`default_nettype wire

/* File: dv/cdw_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cdw_mem_model (
  // clock, reset and speed select
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  // memory port
  input wire cdw_pkg::cdw_mem_req_t req_i,
  output logic [15:0] rdata,
  output logic ack
);
  logic [15:0] mem [0:16383];
  logic [15:0] last_q;
  logic gap_q;
  logic [2:0] cnt_q;
  // ----------------------------------------
  // answer after 1 or 4 cycles, bus garbled between answers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack <= 1'b0;
      rdata <= 16'h0;
      last_q <= 16'h0;
      gap_q <= 1'b0;
      cnt_q <= 3'h0;
    end
    else
    begin
      ack <= 1'b0;
      rdata <= ~last_q;
      gap_q <= 1'b0;
      if (gap_q || !req_i.req)
        cnt_q <= 3'h0;
      else if (cnt_q >= (slow ? 3'h3 : 3'h0))
      begin
        ack <= 1'b1;
        rdata <= mem[req_i.addr[13:0]];
        last_q <= mem[req_i.addr[13:0]];
        gap_q <= 1'b1;
        cnt_q <= 3'h0;
      end
      else
        cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule : cdw_mem_model
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, srst, wb_cyc, wb_stb, wb_we, wb_ack_o, mem_ack, io_strobe, slow;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_dat_o, q;
  cdw_pkg::cdw_mem_req_t mem_o;
  logic [15:0] mem_rdata, in_lines, out_lines;
  logic [9:0] sel_lines;
  int fail_count, total_checks, io_n;
  localparam logic [31:0] IMG [22] = '{32'h0000_0002, 32'h0050_0001, 32'h0010_0100,
    32'h0210_0003, 32'h0062_fffd, 32'h0070_0400, 32'h0072_0300, 32'h0300_0006,
    32'h0400_0009, 32'h0080_8000, 32'h0200_1850, 32'h0201_1e10, 32'h0202_5860,
    32'h0203_d870, 32'h0204_2c80, 32'h0205_0000, 32'h0206_0620, 32'h0220_f2a5,
    32'h0221_b15a, 32'h0222_c020, 32'h0223_4341, 32'h0224_4244};
  cdw_core u_dut (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_o(mem_o), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .input_data_lines(in_lines), .output_data_lines(out_lines),
    .device_select_lines(sel_lines), .io_strobe(io_strobe));
  cdw_mem_model u_mem (.clk(clk), .srst(srst), .slow(slow), .req_i(mem_o),
    .rdata(mem_rdata), .ack(mem_ack));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check(32'(n < 20), 32'h1, "ack wait");
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    check(r, e, m);
  endtask : rchk
  task automatic step(input logic [15:0] acc, input logic [13:0] pc, input logic [5:0] op,
    input logic c);
    int n;
    wb(1'b1, 8'h00, 32'h2, q);
    n = 0;
    q = 32'h2;
    while (q[1] !== 1'b0 && n < 50)
    begin
      wb(1'b0, 8'h10, 32'h0, q);
      n++;
    end
    check(q, {18'h0, op, 7'h0, c}, "status");
    rchk(8'h08, {16'h0, acc}, "acc");
    rchk(8'h04, {18'h0, pc}, "pc");
  endtask : step
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk)
    if (io_strobe === 1'b1)
      io_n++;
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {wb_cyc, wb_stb, wb_we, slow} = 4'h0;
    wb_adr = 8'h0;
    wb_sel = 4'hf;
    wb_dat = 32'h0;
    in_lines = 16'h1234;
    srst = 1'b1;
    foreach (IMG[i])
      u_mem.mem[IMG[i][29:16]] = IMG[i][15:0];
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int a = 4; a < 32; a += 4)
      rchk(a[7:0], 32'h0, "reset value");
    wb(1'b1, 8'h1c, 32'hffff, q);
    rchk(8'h1c, 32'h0, "unmapped");
    wb(1'b1, 8'h0c, 32'ha5a5, q);
    rchk(8'h0c, 32'ha5a5, "ext");
    wb(1'b1, 8'h04, 32'h200, q);
    wb(1'b1, 8'h08, 32'h7fff, q);
    step(16'h8000, 14'h201, 6'h06, 1'b1);
    rchk(8'h14, 32'h0001, "mdr");
    rchk(8'h18, 32'h0201, "mar next fetch");
    wb(1'b1, 8'h10, 32'h1, q);
    step(16'h7ffd, 14'h202, 6'h07, 1'b1);
    rchk(8'h18, 32'h0202, "mar next fetch");
    wb(1'b1, 8'h10, 32'h1, q);
    slow <= 1'b1;
    step(16'h7ffa, 14'h203, 6'h16, 1'b0);
    rchk(8'h18, 32'h0203, "mar next fetch");
    step(16'h8000, 14'h204, 6'h06, 1'b1);
    rchk(8'h18, 32'h0204, "mar next fetch");
    wb(1'b1, 8'h10, 32'h1, q);
    step(16'h8000, 14'h206, 6'h0b, 1'b0);
    step(16'h8000, 14'h220, 6'h01, 1'b0);
    step(16'h8000, 14'h221, 6'h3c, 1'b0);
    check({16'h0, out_lines}, 32'h8000, "output lines");
    check({22'h0, sel_lines}, 32'h2a5, "select lines");
    check(32'(io_n), 32'h1, "strobe count");
    step(16'h1234, 14'h222, 6'h2c, 1'b0);
    check({22'h0, sel_lines}, 32'h15a, "select lines");
    check(32'(io_n), 32'h2, "strobe count");
    step(16'h0000, 14'h223, 6'h30, 1'b0);
    check({16'h0, out_lines}, 32'h8000, "output kept");
    wb(1'b1, 8'h08, 32'h4000, q);
    step(16'h8000, 14'h224, 6'h10, 1'b1);
    step(16'h0004, 14'h225, 6'h10, 1'b1);
    rchk(8'h0c, 32'h5a50, "ext long shift");
    close_out();
  end
endmodule : tb_top
bind cdw_core cdw_core_assertions u_chk (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_o(mem_o),
  .mem_ack(mem_ack), .output_data_lines(output_data_lines),
  .device_select_lines(device_select_lines), .io_strobe(io_strobe));
`default_nettype wire

/* File: include/cdw_consts.svh */
`ifndef CDW_CONSTS_SVH
`define CDW_CONSTS_SVH
// ----------------------------------------
// register bus word offsets
// ----------------------------------------
`define CDW_OFF_CTRL 8'h00
`define CDW_OFF_PC 8'h04
`define CDW_OFF_ACC 8'h08
`define CDW_OFF_EXT 8'h0c
`define CDW_OFF_STATUS 8'h10
`define CDW_OFF_MDR 8'h14
`define CDW_OFF_MAR 8'h18
// ----------------------------------------
// field positions
// ----------------------------------------
`define CDW_CTRL_RUN_BIT 0
`define CDW_CTRL_STEP_BIT 1
`define CDW_STAT_CARRY_BIT 0
`define CDW_STAT_RUN_BIT 1
`define CDW_STAT_OPREG_LSB 8
// ----------------------------------------
// operation codes
// ----------------------------------------
`define CDW_OP_GROUP0 4'h0
`define CDW_OP_JUMP 4'h1
`define CDW_OP_ADD 4'h6
`define CDW_OP_SUB 4'h7
`define CDW_OP_CMP 4'hb
`define CDW_OP_IOT 4'hc
`define CDW_OP6_INPUT 6'h2c
`define CDW_OP6_OUTPUT 6'h3c
`define CDW_OP10_ALS 10'h10d
`define CDW_OP10_LLS 10'h109
`define CDW_WORD_CLEAR_ACC 16'hc020
// ----------------------------------------
// reset values and index word location
// ----------------------------------------
`define CDW_RST_WORD 16'h0000
`define CDW_RST_PC 14'h0000
`define CDW_RST_OPREG 6'h00
`define CDW_INDEX_LOC 16'h0000
`endif

/* File: include/cdw_pkg.sv */
package cdw_pkg;
  // ----------------------------------------
  // instruction word, bit 1 is the msb
  // ----------------------------------------
  typedef struct packed {
    logic ind;
    logic idx;
    logic [3:0] op;
    logic sec;
    logic [8:0] addr;
  } cdw_word_t;
  // ----------------------------------------
  // core memory request
  // ----------------------------------------
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cdw_mem_req_t;
  typedef enum logic [1:0] {
    CLS_MEMREF,
    CLS_IOT,
    CLS_SHIFT,
    CLS_GENERIC
  } cdw_class_t;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DECODE,
    ST_IDX_RD,
    ST_IDX_ADD,
    ST_INDIR,
    ST_OPND,
    ST_EXEC,
    ST_NEXT
  } cdw_state_t;
endpackage : cdw_pkg
